// ==== tffc_pkg.sv ====
// Package for the timer output flip-flop control block
// Behaviour
// - Source select 0 picks even timer match, 1 picks odd timer match.
// - Source select matters only in 8-bit timer mode; ignored otherwise.
// - Control register bits 7 to 4 read undefined; here they read zero.
// - Command write: 00 inverts, 01 sets, 10 clears, 11 leaves flop unchanged.
// - Toggle enable 0 blocks timer inversion; 1 lets selected event invert.
// - Each flop value drives its own timer output pin.
// - In 16-bit mode, simultaneous matches of both timers invert when enabled.
package tffc_pkg;
  localparam int TFFC_PAIRS = 4;
  localparam logic [31:0] TFFC_FLIPFLOP3_CONTROL = 32'hFFFFF10D;
  localparam logic [31:0] TFFC_FLIPFLOP5_CONTROL = 32'hFFFFF115;
  localparam logic [31:0] TFFC_FLIPFLOP7_CONTROL = 32'hFFFFF11D;
  localparam logic [31:0] TFFC_FLIPFLOP9_CONTROL = 32'hFFFFF125;
  localparam int TFFC_SRC_BIT = 0;
  localparam int TFFC_EN_BIT = 1;
  localparam int TFFC_CMD_LO = 2;
  localparam int TFFC_CMD_HI = 3;
  localparam logic [1:0] TFFC_CMD_INVERT = 2'h0;
  localparam logic [1:0] TFFC_CMD_SET = 2'h1;
  localparam logic [1:0] TFFC_CMD_CLEAR = 2'h2;
  localparam logic [1:0] TFFC_CMD_HOLD = 2'h3;
  localparam logic [1:0] TFFC_MODE_8BIT = 2'h0;
  localparam logic [1:0] TFFC_MODE_16BIT = 2'h1;
  localparam logic TFFC_EN_RESET = 1'h0;
  localparam logic TFFC_SRC_RESET = 1'h0;
  localparam logic TFFC_FLOP_RESET = 1'h0;
  localparam logic [7:0] TFFC_RDATA_RESET = 8'h00;

  typedef struct packed {
    logic write;
    logic [1:0] cmd;
    logic enable;
    logic source;
  } tffc_ctl_t;

  typedef struct packed {
    logic [1:0] mode;
    logic match_even;
    logic match_odd;
  } tffc_timer_t;
endpackage

// ==== tffc_pair.sv ====
// One output flip-flop with its control bits
`timescale 1ns/100ps
module tffc_pair
  import tffc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire tffc_ctl_t ctl,
  input wire tffc_timer_t tmr,
  output logic enable,
  output logic source,
  output logic flop
);
  logic enable_reg, enable_next;
  logic source_reg, source_next;
  logic flop_reg, flop_next;
  logic hw_event;

  always_comb begin
    enable_next = enable_reg;
    source_next = source_reg;
    hw_event = 1'b0;
    if (tmr.mode == TFFC_MODE_8BIT) begin
      hw_event = source_reg ? tmr.match_odd : tmr.match_even;
    end else if (tmr.mode == TFFC_MODE_16BIT) begin
      hw_event = tmr.match_even & tmr.match_odd;
    end
    flop_next = flop_reg;
    if (enable_reg && hw_event) begin
      flop_next = ~flop_reg;
    end
    if (ctl.write) begin
      enable_next = ctl.enable;
      source_next = ctl.source;
      case (ctl.cmd)
        TFFC_CMD_INVERT: flop_next = ~flop_reg;
        TFFC_CMD_SET: flop_next = 1'b1;
        TFFC_CMD_CLEAR: flop_next = 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= TFFC_EN_RESET;
      source_reg <= TFFC_SRC_RESET;
      flop_reg <= TFFC_FLOP_RESET;
    end else begin
      enable_reg <= enable_next;
      source_reg <= source_next;
      flop_reg <= flop_next;
    end
  end

  assign enable = enable_reg;
  assign source = source_reg;
  assign flop = flop_reg;
endmodule

// ==== tffc_top.sv ====
// Register port and four output flip-flops for timer pairs 2/3 to 8/9
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module tffc_top
  import tffc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire tffc_timer_t [TFFC_PAIRS-1:0] timers,
  output logic [TFFC_PAIRS-1:0] out_pin
);
  // Control bits held inside each pair module
  logic [TFFC_PAIRS-1:0] en_q;
  logic [TFFC_PAIRS-1:0] src_q;
  logic [TFFC_PAIRS-1:0] flop_q;

  // Register hits and write fields
  logic [TFFC_PAIRS-1:0] wr_hit;
  logic [TFFC_PAIRS-1:0] rd_hit;
  logic [1:0] wr_cmd;
  logic wr_enable;
  logic wr_source;

  // Write carriers, one per pair
  tffc_ctl_t ctl23;
  tffc_ctl_t ctl45;
  tffc_ctl_t ctl67;
  tffc_ctl_t ctl89;

  // Read-back image of each control register
  logic [7:0] view23;
  logic [7:0] view45;
  logic [7:0] view67;
  logic [7:0] view89;

  // Output registers
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [TFFC_PAIRS-1:0] out_reg;
  logic [TFFC_PAIRS-1:0] out_next;

  // Full address compare; an unmapped address hits nothing
  always_comb begin
    wr_hit = '0;
    rd_hit = '0;
    case (addr)
      TFFC_FLIPFLOP3_CONTROL: begin
        wr_hit[0] = wr_en;
        rd_hit[0] = rd_en;
      end
      TFFC_FLIPFLOP5_CONTROL: begin
        wr_hit[1] = wr_en;
        rd_hit[1] = rd_en;
      end
      TFFC_FLIPFLOP7_CONTROL: begin
        wr_hit[2] = wr_en;
        rd_hit[2] = rd_en;
      end
      TFFC_FLIPFLOP9_CONTROL: begin
        wr_hit[3] = wr_en;
        rd_hit[3] = rd_en;
      end
      default: begin
        wr_hit = '0;
        rd_hit = '0;
      end
    endcase
  end

  // Fields of a write byte; bits 7 to 4 are dropped
  always_comb begin
    wr_cmd = wdata[TFFC_CMD_HI:TFFC_CMD_LO];
    wr_enable = wdata[TFFC_EN_BIT];
    wr_source = wdata[TFFC_SRC_BIT];
  end

  // Pair 2/3 write carrier and flop
  always_comb begin
    ctl23.write = wr_hit[0];
    ctl23.cmd = wr_cmd;
    ctl23.enable = wr_enable;
    ctl23.source = wr_source;
  end

  tffc_pair u_pair23 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl23),
    .tmr(timers[0]),
    .enable(en_q[0]),
    .source(src_q[0]),
    .flop(flop_q[0])
  );

  // Pair 2/3 read-back image
  always_comb begin
    view23 = TFFC_RDATA_RESET;
    view23[TFFC_CMD_HI:TFFC_CMD_LO] = TFFC_CMD_HOLD;
    view23[TFFC_EN_BIT] = en_q[0];
    view23[TFFC_SRC_BIT] = src_q[0];
  end

  // Pair 4/5 write carrier and flop
  always_comb begin
    ctl45.write = wr_hit[1];
    ctl45.cmd = wr_cmd;
    ctl45.enable = wr_enable;
    ctl45.source = wr_source;
  end

  tffc_pair u_pair45 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl45),
    .tmr(timers[1]),
    .enable(en_q[1]),
    .source(src_q[1]),
    .flop(flop_q[1])
  );

  // Pair 4/5 read-back image
  always_comb begin
    view45 = TFFC_RDATA_RESET;
    view45[TFFC_CMD_HI:TFFC_CMD_LO] = TFFC_CMD_HOLD;
    view45[TFFC_EN_BIT] = en_q[1];
    view45[TFFC_SRC_BIT] = src_q[1];
  end

  // Pair 6/7 write carrier and flop
  always_comb begin
    ctl67.write = wr_hit[2];
    ctl67.cmd = wr_cmd;
    ctl67.enable = wr_enable;
    ctl67.source = wr_source;
  end

  tffc_pair u_pair67 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl67),
    .tmr(timers[2]),
    .enable(en_q[2]),
    .source(src_q[2]),
    .flop(flop_q[2])
  );

  // Pair 6/7 read-back image
  always_comb begin
    view67 = TFFC_RDATA_RESET;
    view67[TFFC_CMD_HI:TFFC_CMD_LO] = TFFC_CMD_HOLD;
    view67[TFFC_EN_BIT] = en_q[2];
    view67[TFFC_SRC_BIT] = src_q[2];
  end

  // Pair 8/9 write carrier and flop
  always_comb begin
    ctl89.write = wr_hit[3];
    ctl89.cmd = wr_cmd;
    ctl89.enable = wr_enable;
    ctl89.source = wr_source;
  end

  tffc_pair u_pair89 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl89),
    .tmr(timers[3]),
    .enable(en_q[3]),
    .source(src_q[3]),
    .flop(flop_q[3])
  );

  // Pair 8/9 read-back image
  always_comb begin
    view89 = TFFC_RDATA_RESET;
    view89[TFFC_CMD_HI:TFFC_CMD_LO] = TFFC_CMD_HOLD;
    view89[TFFC_EN_BIT] = en_q[3];
    view89[TFFC_SRC_BIT] = src_q[3];
  end

  // Read data stand one cycle after the strobe and read zero otherwise
  always_comb begin
    rdata_next = TFFC_RDATA_RESET;
    if (rd_hit[0]) begin
      rdata_next = view23;
    end else if (rd_hit[1]) begin
      rdata_next = view45;
    end else if (rd_hit[2]) begin
      rdata_next = view67;
    end else if (rd_hit[3]) begin
      rdata_next = view89;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= TFFC_RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Pins follow the flops one cycle later
  always_comb begin
    out_next = flop_q;
  end

  // Pin register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= {TFFC_PAIRS{TFFC_FLOP_RESET}};
    end else begin
      out_reg <= out_next;
    end
  end

  assign rdata = rdata_reg;
  assign out_pin = out_reg;
endmodule

// ==== tffc_top_sva.sv ====
// Checker for the timer flip-flop control ports
`timescale 1ns/100ps
module tffc_top_sva import tffc_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire tffc_timer_t [TFFC_PAIRS-1:0] timers,
  input wire logic [TFFC_PAIRS-1:0] out_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] c0;
  wire w = wr_en && addr == TFFC_FLIPFLOP3_CONTROL;
  wire q = !wr_en && c0[1];
  wire [1:0] m = timers[0].mode;
  wire e = timers[0].match_even;
  wire o = timers[0].match_odd;
  wire p = out_pin[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) c0 <= 2'h0;
    else if (w) c0 <= wdata[1:0];
  end
  property p_set; w && wdata[3:2] == 2'h1 |-> ##2 p; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; w && wdata[3:2] == 2'h2 |-> ##2 !p; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_inv; w && wdata[3:2] == 2'h0 |-> ##2 p != $past(p); endproperty
  a_inv: assert property (p_inv) else $error("invert");
  property p_rd; rd_en && addr == TFFC_FLIPFLOP3_CONTROL |=> rdata == {6'h03, c0}; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_sel; q && m == 2'h0 && (c0[0] ? o : e) |-> ##2 p != $past(p); endproperty
  a_sel: assert property (p_sel) else $error("event");
  property p_ign; q && c0[0] && m == 2'h0 && !o |-> ##2 $stable(p); endproperty
  a_ign: assert property (p_ign) else $error("source");
  property p_16; q && m == 2'h1 && e && o |-> ##2 p != $past(p); endproperty
  a_16: assert property (p_16) else $error("wide");
  property p_off; !wr_en && (!c0[1] || m[1]) |-> ##2 $stable(p); endproperty
  a_off: assert property (p_off) else $error("off");
  c_set: cover property (w && wdata[3:2] == 2'h1);
  c_sel: cover property (q && m == 2'h0 && c0[0] && o);
  c_16: cover property (q && m == 2'h1 && e && o);
endmodule
bind tffc_top tffc_top_sva u_sva (.*);

// ==== tffc_top_test.sv ====
// Directed test of the timer flip-flop control block
`timescale 1ns/100ps
module tffc_top_test import tffc_pkg::*;;
  logic ref_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0;
  logic [31:0] addr = '0;
  logic [7:0] wdata = '0, rdata, rv;
  tffc_timer_t [TFFC_PAIRS-1:0] timers = '0;
  logic [TFFC_PAIRS-1:0] out_pin;
  logic [31:0] a [4] = '{TFFC_FLIPFLOP3_CONTROL, TFFC_FLIPFLOP5_CONTROL,
    TFFC_FLIPFLOP7_CONTROL, TFFC_FLIPFLOP9_CONTROL};
  int num_errors = 0, checked = 0, i = 0;
  always #10 ref_clk = ~ref_clk;
  tffc_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timers(timers), .out_pin(out_pin));
  task ck(input string n, input logic [7:0] x, v);
    checked++;
    if (v !== x) begin
      $display("MISMATCH %s exp %h got %h", n, x, v);
      num_errors++;
    end
  endtask
  function tffc_timer_t [3:0] ev(input logic [1:0] md, eo);
    ev = '0;
    ev[i] = {md, eo};
  endfunction
  // One access or timer pulse, then pin and read data compared
  task op(input logic w, r, input logic [31:0] ad, input logic [7:0] d,
    input tffc_timer_t [3:0] t, input logic ep, input logic [7:0] er);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= r;
    addr <= ad;
    wdata <= d;
    timers <= t;
    @(posedge ref_clk);
    wr_en <= 0;
    rd_en <= 0;
    timers <= '0;
    #1 rv = rdata;
    @(posedge ref_clk);
    #1 ck("rdata", er, rv);
    ck("out_pin", {7'h00, ep}, {7'h00, out_pin[i]});
  endtask
  task stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1;
    for (i = 0; i < 4; i++) begin
      op(0, 1, a[i], 8'h00, 0, 0, 8'h0C);
      op(1, 0, a[i], 8'h04, 0, 1, 8'h00);
      op(1, 0, a[i], 8'h08, 0, 0, 8'h00);
      op(1, 0, a[i], 8'h00, 0, 1, 8'h00);
      op(1, 0, a[i], 8'h0F, 0, 1, 8'h00);
      op(0, 1, a[i], 8'h00, 0, 1, 8'h0F);
      op(0, 0, 0, 8'h00, ev(2'h0, 2'h2), 1, 8'h00);
      op(0, 0, 0, 8'h00, ev(2'h0, 2'h1), 0, 8'h00);
      op(1, 0, a[i], 8'h0E, 0, 0, 8'h00);
      op(0, 0, 0, 8'h00, ev(2'h0, 2'h2), 1, 8'h00);
      op(0, 0, 0, 8'h00, ev(2'h1, 2'h3), 0, 8'h00);
      op(0, 0, 0, 8'h00, ev(2'h1, 2'h1), 0, 8'h00);
      op(0, 0, 0, 8'h00, ev(2'h2, 2'h3), 0, 8'h00);
      op(1, 0, a[i], 8'h0C, 0, 0, 8'h00);
      op(0, 0, 0, 8'h00, ev(2'h0, 2'h3), 0, 8'h00);
    end
    i = 0;
    op(0, 1, 32'hFFFFF10C, 8'h00, 0, 0, 8'h00);
    stop_test();
  end
endmodule
